//--- rtl/coc_pkg.sv
package coc_pkg;

	// serial slave address (7 bits) and byte positions in a frame
	localparam logic [6:0] SLAVE_ADDR      = 7'h69;
	localparam logic [1:0] BYTE_ADDR       = 2'h0;
	localparam logic [1:0] BYTE_FIRST_DATA = 2'h3;
	localparam logic [1:0] BYTE_STEP       = 2'h1;
	localparam logic [2:0] BIT_FIRST       = 3'h0;
	localparam logic [2:0] BIT_LAST        = 3'h7;
	localparam logic [2:0] BIT_STEP        = 3'h1;
	localparam logic [2:0] PTR_FIRST       = 3'h0;
	localparam logic [2:0] PTR_STEP        = 3'h1;

	// register indices in stream order
	localparam logic [2:0] REG_FREQ  = 3'h0;
	localparam logic [2:0] REG_CPU   = 3'h1;
	localparam logic [2:0] REG_PCI   = 3'h2;
	localparam logic [2:0] REG_MEM   = 3'h3;
	localparam logic [2:0] REG_STRAP = 3'h4;
	localparam logic [2:0] REG_REF   = 3'h5;
	localparam logic [2:0] REG_ID    = 3'h6;

	// arbitrary identification value
	localparam logic [7:0] CHIP_ID = 8'h5a;

	// field positions
	localparam int R1_SINGLE_MEM = 3;
	localparam int R1_PROC       = 1;
	localparam int R1_CHIPSET    = 0;
	localparam int R2_PCI_FIRST  = 6;
	localparam int R2_PCI_REST   = 0;
	localparam int R3_RATE_SEL   = 6;
	localparam int R3_DEDICATED  = 5;
	localparam int R3_SHARED     = 4;
	localparam int R3_MEM_GROUP  = 0;
	localparam int R4_STRAP      = 4;
	localparam int R4_DEPTH      = 1;
	localparam int R4_SPREAD     = 0;
	localparam int R5_REF_SECOND = 1;
	localparam int R5_REF_FIRST  = 0;

	// reset values, writable masks, bits that read fixed at one
	localparam logic [7:0] R1_RST   = 8'h0b;
	localparam logic [7:0] R1_MASK  = 8'h0b;
	localparam logic [7:0] R2_RST   = 8'hff;
	localparam logic [7:0] R2_MASK  = 8'h5f;
	localparam logic [7:0] R2_FIXED = 8'ha0;
	localparam logic [7:0] R3_RST   = 8'h37;
	localparam logic [7:0] R3_MASK  = 8'h77;
	localparam logic [3:0] R4_RST   = 4'h0;
	localparam logic [3:0] R4_MASK  = 4'h3;
	localparam logic [7:0] R5_RST   = 8'h03;
	localparam logic [7:0] R5_MASK  = 8'h03;
	localparam logic [7:0] BYTE_ZERO = 8'h00;

	localparam int CH_N = 16;

	// run enables, bit order matches the phase input vector
	typedef struct packed {
		logic       reference_out_second;
		logic       reference_out_first;
		logic [2:0] memory_group;
		logic       shared_peripheral_clock;
		logic       dedicated_48;
		logic [5:0] pci_clock;
		logic       single_memory_clock;
		logic       chipset_clock;
		logic       proc_clock;
	} coc_clk_en_t;

	typedef struct packed {
		logic shared_pin_rate_select;
		logic spread_depth_half;
		logic spread_enable;
	} coc_mode_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RX   = 3'b001,
		ST_ACK  = 3'b010,
		ST_TX   = 3'b011,
		ST_RACK = 3'b100
	} coc_i2c_st_t;

endpackage : coc_pkg

//--- rtl/coc_clk_park.sv
`timescale 1ns/1ps
module coc_clk_park #(
	parameter logic RUN_AT_RESET = 1'b1
) (
	// clock and reset
	input  wire logic core_clk,
	input  wire logic reset,
	// level of the gated clock, from outside the domain
	input  wire logic phase_in,
	// requested and effective run state
	input  wire logic run_req,
	output logic      run_out
);

	logic s1_ff;
	logic s2_ff;
	logic s3_ff;
	logic lvl_ff;
	logic run_ff;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			s1_ff <= 1'b0;
			s2_ff <= 1'b0;
			s3_ff <= 1'b0;
		end else begin
			s1_ff <= phase_in;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			lvl_ff <= 1'b0;
		end else if (s2_ff == s3_ff) begin
			lvl_ff <= s3_ff;
		end
	end

	// only switch in the low phase, so a high phase is never cut short
	always_ff @(posedge core_clk) begin
		if (reset) begin
			run_ff <= RUN_AT_RESET;
		end else if (!lvl_ff) begin
			run_ff <= run_req;
		end
	end

	assign run_out = run_ff;

	park_low_a: assert property (@(posedge core_clk) disable iff (reset)
		$changed(run_ff) |-> !$past(lvl_ff))
		else $error("run state changed during a high phase");

endmodule : coc_clk_park

//--- rtl/coc_regs.sv
`timescale 1ns/1ps
// Function
// - bit 3 of the cpu/memory enable register runs the single memory clock, resetting to one.
// - bit 1 of that register runs both processor clock outputs together, resetting to one.
// - bit 0 of that register runs the chipset clock, resetting to one.
// - the pci enable register holds one run bit per pci clock, bit 6 first and bits 0-4 the rest, reset all ones.
// - bit 6 of the memory/peripheral register picks 24 or 48 MHz on the shared pin, resetting to zero.
// - bits 5 and 4 of that register run the dedicated 48 MHz and the shared clock, resetting to one.
// - bits 0 to 2 of that register run the three memory clock groups, resetting to one.
// - the top nibble of the strap register reads back the straps latched after reset.
// - bit 1 of the strap register picks the spread depth, resetting to zero.
// - bit 0 of the strap register enables spread modulation, resetting to zero.
// - bits 1 and 0 of the reference register run the two reference outputs, resetting to one.
// - register 6 returns a fixed identification byte and ignores writes.
// - after the address come two acknowledged dummy bytes, then data bytes load registers from 0 upward.
module coc_regs (
	// clock and reset
	input  wire logic            core_clk,
	input  wire logic            reset,
	// two-wire serial pins
	input  wire logic            scl_in,
	input  wire logic            sda_in,
	output logic                 sda_out,
	output logic                 sda_oe,
	// frequency straps, active low pins
	input  wire logic [3:0]      strap_select_bits_n,
	// present level of each gated clock
	input  wire logic [15:0]     clk_phase,
	// run enables and modes
	output coc_pkg::coc_clk_en_t clk_run,
	output coc_pkg::coc_mode_t   mode
);

	logic [2:0]          scl_sync_ff;
	logic [2:0]          sda_sync_ff;
	logic                scl_lvl_ff;
	logic                sda_lvl_ff;
	logic                scl_prev_ff;
	logic                sda_prev_ff;
	logic                scl_rise;
	logic                scl_fall;
	logic                bus_start;
	logic                bus_stop;

	coc_pkg::coc_i2c_st_t st_ff;
	logic [2:0]          cnt_ff;
	logic [7:0]          shift_ff;
	logic [1:0]          byte_num_ff;
	logic                rw_ff;
	logic                done_ff;
	logic                host_ack_ff;
	logic [2:0]          ptr_ff;
	logic                sda_oe_ff;
	logic                sda_out_ff;
	logic                wr_stb_ff;
	logic [2:0]          wr_idx_ff;
	logic [7:0]          wr_data_ff;
	logic [7:0]          tx_byte;

	logic [7:0]          reg1_ff;
	logic [7:0]          reg2_ff;
	logic [7:0]          reg3_ff;
	logic [3:0]          reg4_ff;
	logic [7:0]          reg5_ff;
	logic [3:0]          strap_s1_ff;
	logic [3:0]          strap_s2_ff;
	logic [3:0]          strap_s3_ff;
	logic [3:0]          strap_ff;
	logic                strap_taken_ff;
	coc_pkg::coc_mode_t  mode_ff;
	logic [15:0]         run_req;
	logic [15:0]         run_vec;

	function automatic logic [7:0] rd_byte(input logic [2:0] idx);
		logic [7:0] val;
		val = coc_pkg::BYTE_ZERO;
		unique case (idx)
			coc_pkg::REG_CPU:   val = reg1_ff;
			coc_pkg::REG_PCI:   val = reg2_ff;
			coc_pkg::REG_MEM:   val = reg3_ff;
			coc_pkg::REG_STRAP: val = {strap_ff, reg4_ff};
			coc_pkg::REG_REF:   val = reg5_ff;
			coc_pkg::REG_ID:    val = coc_pkg::CHIP_ID;
			default:            val = coc_pkg::BYTE_ZERO;
		endcase
		return val;
	endfunction : rd_byte

	// pin synchronisers; a change counts once stages two and three agree
	always_ff @(posedge core_clk) begin
		if (reset) begin
			scl_sync_ff <= 3'h7;
			sda_sync_ff <= 3'h7;
		end else begin
			scl_sync_ff <= {scl_sync_ff[1:0], scl_in};
			sda_sync_ff <= {sda_sync_ff[1:0], sda_in};
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			scl_lvl_ff  <= 1'b1;
			sda_lvl_ff  <= 1'b1;
			scl_prev_ff <= 1'b1;
			sda_prev_ff <= 1'b1;
		end else begin
			if (scl_sync_ff[1] == scl_sync_ff[2]) begin
				scl_lvl_ff <= scl_sync_ff[2];
			end
			if (sda_sync_ff[1] == sda_sync_ff[2]) begin
				sda_lvl_ff <= sda_sync_ff[2];
			end
			scl_prev_ff <= scl_lvl_ff;
			sda_prev_ff <= sda_lvl_ff;
		end
	end

	assign scl_rise  = scl_lvl_ff && !scl_prev_ff;
	assign scl_fall  = !scl_lvl_ff && scl_prev_ff;
	assign bus_start = scl_lvl_ff && scl_prev_ff && sda_prev_ff && !sda_lvl_ff;
	assign bus_stop  = scl_lvl_ff && scl_prev_ff && !sda_prev_ff && sda_lvl_ff;
	assign tx_byte   = rd_byte(ptr_ff);

	// serial slave sequencer
	always_ff @(posedge core_clk) begin
		if (reset) begin
			st_ff       <= coc_pkg::ST_IDLE;
			cnt_ff      <= coc_pkg::BIT_FIRST;
			shift_ff    <= coc_pkg::BYTE_ZERO;
			byte_num_ff <= coc_pkg::BYTE_ADDR;
			rw_ff       <= 1'b0;
			done_ff     <= 1'b0;
			host_ack_ff <= 1'b0;
			ptr_ff      <= coc_pkg::PTR_FIRST;
			sda_oe_ff   <= 1'b0;
			wr_stb_ff   <= 1'b0;
			wr_idx_ff   <= coc_pkg::PTR_FIRST;
			wr_data_ff  <= coc_pkg::BYTE_ZERO;
		end else begin
			wr_stb_ff <= 1'b0;
			if (bus_start) begin
				st_ff       <= coc_pkg::ST_RX;
				cnt_ff      <= coc_pkg::BIT_FIRST;
				byte_num_ff <= coc_pkg::BYTE_ADDR;
				done_ff     <= 1'b0;
				sda_oe_ff   <= 1'b0;
			end else if (bus_stop) begin
				st_ff     <= coc_pkg::ST_IDLE;
				sda_oe_ff <= 1'b0;
			end else begin
				unique case (st_ff)
					coc_pkg::ST_IDLE: begin
					end
					coc_pkg::ST_RX: begin
						if (scl_rise) begin
							shift_ff <= {shift_ff[6:0], sda_lvl_ff};
							cnt_ff   <= cnt_ff + coc_pkg::BIT_STEP;
							done_ff  <= (cnt_ff == coc_pkg::BIT_LAST);
						end else if (scl_fall && done_ff) begin
							done_ff <= 1'b0;
							cnt_ff  <= coc_pkg::BIT_FIRST;
							if (byte_num_ff == coc_pkg::BYTE_ADDR) begin
								if (shift_ff[7:1] == coc_pkg::SLAVE_ADDR) begin
									sda_oe_ff   <= 1'b1;
									rw_ff       <= shift_ff[0];
									ptr_ff      <= coc_pkg::PTR_FIRST;
									byte_num_ff <= coc_pkg::BYTE_STEP;
									st_ff       <= coc_pkg::ST_ACK;
								end else begin
									st_ff <= coc_pkg::ST_IDLE;
								end
							end else begin
								// command and count bytes are acknowledged and dropped
								sda_oe_ff <= 1'b1;
								st_ff     <= coc_pkg::ST_ACK;
								if (byte_num_ff == coc_pkg::BYTE_FIRST_DATA) begin
									wr_stb_ff  <= 1'b1;
									wr_idx_ff  <= ptr_ff;
									wr_data_ff <= shift_ff;
									ptr_ff     <= ptr_ff + coc_pkg::PTR_STEP;
								end else begin
									byte_num_ff <= byte_num_ff + coc_pkg::BYTE_STEP;
								end
							end
						end
					end
					coc_pkg::ST_ACK: begin
						if (scl_fall) begin
							if (rw_ff) begin
								st_ff     <= coc_pkg::ST_TX;
								shift_ff  <= tx_byte;
								sda_oe_ff <= !tx_byte[7];
								ptr_ff    <= ptr_ff + coc_pkg::PTR_STEP;
								cnt_ff    <= coc_pkg::BIT_FIRST;
							end else begin
								sda_oe_ff <= 1'b0;
								st_ff     <= coc_pkg::ST_RX;
							end
						end
					end
					coc_pkg::ST_TX: begin
						if (scl_fall) begin
							if (cnt_ff == coc_pkg::BIT_LAST) begin
								sda_oe_ff <= 1'b0;
								st_ff     <= coc_pkg::ST_RACK;
							end else begin
								cnt_ff    <= cnt_ff + coc_pkg::BIT_STEP;
								sda_oe_ff <= !shift_ff[6];
								shift_ff  <= {shift_ff[6:0], 1'b0};
							end
						end
					end
					coc_pkg::ST_RACK: begin
						if (scl_rise) begin
							host_ack_ff <= !sda_lvl_ff;
						end else if (scl_fall) begin
							if (host_ack_ff) begin
								st_ff     <= coc_pkg::ST_TX;
								shift_ff  <= tx_byte;
								sda_oe_ff <= !tx_byte[7];
								ptr_ff    <= ptr_ff + coc_pkg::PTR_STEP;
								cnt_ff    <= coc_pkg::BIT_FIRST;
							end else begin
								st_ff <= coc_pkg::ST_IDLE;
							end
						end
					end
					default: begin
						st_ff     <= coc_pkg::ST_IDLE;
						sda_oe_ff <= 1'b0;
					end
				endcase
			end
		end
	end

	// open drain: only ever pulls low
	always_ff @(posedge core_clk) begin
		sda_out_ff <= 1'b0;
	end

	// register file; index 0 and the id byte take no write
	always_ff @(posedge core_clk) begin
		if (reset) begin
			reg1_ff <= coc_pkg::R1_RST;
			reg2_ff <= coc_pkg::R2_RST;
			reg3_ff <= coc_pkg::R3_RST;
			reg4_ff <= coc_pkg::R4_RST;
			reg5_ff <= coc_pkg::R5_RST;
		end else if (wr_stb_ff) begin
			unique case (wr_idx_ff)
				coc_pkg::REG_CPU:   reg1_ff <= wr_data_ff & coc_pkg::R1_MASK;
				coc_pkg::REG_PCI:   reg2_ff <= (wr_data_ff & coc_pkg::R2_MASK) | coc_pkg::R2_FIXED;
				coc_pkg::REG_MEM:   reg3_ff <= wr_data_ff & coc_pkg::R3_MASK;
				coc_pkg::REG_STRAP: reg4_ff <= wr_data_ff[3:0] & coc_pkg::R4_MASK;
				coc_pkg::REG_REF:   reg5_ff <= wr_data_ff & coc_pkg::R5_MASK;
				default: begin
				end
			endcase
		end
	end

	// chain runs through reset, so stages two and three hold the pins when capture opens
	always_ff @(posedge core_clk) begin
		strap_s1_ff <= strap_select_bits_n;
		strap_s2_ff <= strap_s1_ff;
		strap_s3_ff <= strap_s2_ff;
	end

	// strap capture once the synchronised level has settled after reset
	always_ff @(posedge core_clk) begin
		if (reset) begin
			strap_ff       <= 4'h0;
			strap_taken_ff <= 1'b0;
		end else if (!strap_taken_ff && (strap_s2_ff == strap_s3_ff)) begin
			strap_ff       <= strap_s3_ff;
			strap_taken_ff <= 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			mode_ff <= '0;
		end else begin
			mode_ff.shared_pin_rate_select <= reg3_ff[coc_pkg::R3_RATE_SEL];
			mode_ff.spread_depth_half      <= reg4_ff[coc_pkg::R4_DEPTH];
			mode_ff.spread_enable          <= reg4_ff[coc_pkg::R4_SPREAD];
		end
	end

	always_comb begin
		run_req = {reg5_ff[coc_pkg::R5_REF_SECOND], reg5_ff[coc_pkg::R5_REF_FIRST],
			reg3_ff[coc_pkg::R3_MEM_GROUP +: 3],
			reg3_ff[coc_pkg::R3_SHARED], reg3_ff[coc_pkg::R3_DEDICATED],
			reg2_ff[coc_pkg::R2_PCI_REST +: 5], reg2_ff[coc_pkg::R2_PCI_FIRST],
			reg1_ff[coc_pkg::R1_SINGLE_MEM], reg1_ff[coc_pkg::R1_CHIPSET],
			reg1_ff[coc_pkg::R1_PROC]};
	end

	// the processor pair shares one gate, so true and complement never split
	for (genvar i = 0; i < coc_pkg::CH_N; i++) begin : g_park
		coc_clk_park #(
			.RUN_AT_RESET (1'b1)
		) u_park (
			.core_clk (core_clk),
			.reset    (reset),
			.phase_in (clk_phase[i]),
			.run_req  (run_req[i]),
			.run_out  (run_vec[i])
		);
	end

	assign clk_run = coc_pkg::coc_clk_en_t'(run_vec);
	assign mode    = mode_ff;
	assign sda_out = sda_out_ff;
	assign sda_oe  = sda_oe_ff;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	cpu_reset_a: assert property ($fell(reset) |-> reg1_ff == coc_pkg::R1_RST)
		else $error("cpu enable register reset value wrong");
	single_mem_wr_a: assert property (wr_stb_ff && wr_idx_ff == coc_pkg::REG_CPU |=>
		reg1_ff[coc_pkg::R1_SINGLE_MEM] == $past(wr_data_ff[coc_pkg::R1_SINGLE_MEM]))
		else $error("single memory enable not written");
	proc_pair_a: assert property (wr_stb_ff && wr_idx_ff == coc_pkg::REG_CPU |=> ##1
		run_req[0] == $past(wr_data_ff[coc_pkg::R1_PROC], 2))
		else $error("processor pair request not following write");
	pci_fixed_a: assert property ((reg2_ff & coc_pkg::R2_FIXED) == coc_pkg::R2_FIXED)
		else $error("pci reserved bits not reading one");
	mem_reset_a: assert property ($fell(reset) |-> reg3_ff == coc_pkg::R3_RST)
		else $error("memory/peripheral register reset value wrong");
	rate_sel_a: assert property (wr_stb_ff && wr_idx_ff == coc_pkg::REG_MEM |=> ##1
		mode_ff.shared_pin_rate_select == $past(wr_data_ff[coc_pkg::R3_RATE_SEL], 2))
		else $error("shared pin rate select not following write");
	strap_cap_a: assert property ($rose(strap_taken_ff) |-> strap_ff == $past(strap_s3_ff))
		else $error("strap value not captured");
	spread_a: assert property (wr_stb_ff && wr_idx_ff == coc_pkg::REG_STRAP |=> ##1
		mode_ff.spread_enable == $past(wr_data_ff[coc_pkg::R4_SPREAD], 2) &&
		mode_ff.spread_depth_half == $past(wr_data_ff[coc_pkg::R4_DEPTH], 2))
		else $error("spread controls not following write");
	ref_reset_a: assert property ($fell(reset) |-> reg5_ff == coc_pkg::R5_RST)
		else $error("reference register reset value wrong");
	id_fixed_a: assert property (rw_ff && scl_fall && ptr_ff == coc_pkg::REG_ID &&
		(st_ff == coc_pkg::ST_ACK || (st_ff == coc_pkg::ST_RACK && host_ack_ff)) && !bus_start && !bus_stop
		|=> shift_ff == coc_pkg::CHIP_ID)
		else $error("identification byte not loaded for read");
	dummy_ack_a: assert property (st_ff == coc_pkg::ST_RX && scl_fall && done_ff &&
		byte_num_ff != coc_pkg::BYTE_ADDR && !bus_start && !bus_stop |=> sda_oe_ff && st_ff == coc_pkg::ST_ACK)
		else $error("byte after address not acknowledged");
	data_load_a: assert property (st_ff == coc_pkg::ST_RX && scl_fall && done_ff &&
		byte_num_ff == coc_pkg::BYTE_FIRST_DATA && !bus_start && !bus_stop |=>
		wr_stb_ff && wr_idx_ff == $past(ptr_ff))
		else $error("data byte not loaded at pointer");

	write_cov_c: cover property (wr_stb_ff && wr_idx_ff == coc_pkg::REG_MEM);
	read_cov_c: cover property (st_ff == coc_pkg::ST_ACK && rw_ff ##[1:1000] st_ff == coc_pkg::ST_TX);
	nack_cov_c: cover property (st_ff == coc_pkg::ST_RACK ##1 st_ff == coc_pkg::ST_IDLE);
	stop_cov_c: cover property ($fell(run_vec[0]));

endmodule : coc_regs

//--- bench/coc_host_model.sv
`timescale 1ns/1ps
module coc_host_model (
	// clock
	input  wire logic core_clk,
	// device pull on the data wire
	input  wire logic sda_oe,
	// pin levels seen by the device
	output logic      scl,
	output logic      sda
);
	logic hsda;
	int   half;

	// wired-and with pull-up, so a released wire reads high
	assign sda = hsda & ~sda_oe;

	initial begin
		scl  = 1'b1;
		hsda = 1'b1;
		half = 12;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask : tick

	// data moves mid low phase, giving setup and hold of half/2 each
	task automatic bit_xfer(input logic b, output logic seen);
		tick(half / 2);
		hsda <= b;
		tick(half - half / 2);
		scl <= 1'b1;
		tick(half / 2);
		seen = sda;
		tick(half - half / 2);
		scl <= 1'b0;
	endtask : bit_xfer

	// also serves as repeated start, since it begins from clock low or idle
	task automatic start_cond();
		tick(half / 2);
		hsda <= 1'b1;
		tick(half / 2);
		scl <= 1'b1;
		tick(half);
		hsda <= 1'b0;
		tick(half);
		scl <= 1'b0;
	endtask : start_cond

	// clock then stands high between frames
	task automatic stop_cond();
		tick(half / 2);
		hsda <= 1'b0;
		tick(half / 2);
		scl <= 1'b1;
		tick(half);
		hsda <= 1'b1;
		tick(half);
	endtask : stop_cond

	task automatic send_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_xfer(d[i], s);
		end
		bit_xfer(1'b1, s);
		ack = ~s;
	endtask : send_byte

	task automatic recv_byte(input logic last, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_xfer(1'b1, s);
			d[i] = s;
		end
		bit_xfer(last, s);
	endtask : recv_byte

	// address, command, count, then data bytes in stream order
	task automatic write_frame(input logic [7:0] q[$], output int acks);
		logic a;
		acks = 0;
		start_cond();
		foreach (q[i]) begin
			send_byte(q[i], a);
			acks += int'(a);
		end
		stop_cond();
	endtask : write_frame

	// host acks each byte but the last, which it refuses
	task automatic read_frame(input int n, output logic [7:0] r [0:7], output logic ack);
		start_cond();
		send_byte({coc_pkg::SLAVE_ADDR, 1'b1}, ack);
		for (int i = 0; i < n; i++) begin
			recv_byte(i == n - 1, r[i]);
		end
		stop_cond();
	endtask : read_frame
endmodule : coc_host_model

//--- bench/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic                 core_clk;
	logic                 reset;
	logic [3:0]           straps_n;
	logic [15:0]          clk_phase;
	logic [15:0]          hold_hi;
	logic [2:0]           ph_cnt;
	logic                 scl;
	logic                 sda;
	logic                 sda_out;
	logic                 sda_oe;
	coc_pkg::coc_clk_en_t clk_run;
	coc_pkg::coc_mode_t   mode;
	int                   n_errors;
	int                   compares;
	int                   acks;
	logic [7:0]           rb [0:7];
	logic                 ack;
	logic [7:0]           q [$];
	logic [7:0]           pat [0:3][0:4];

	coc_regs i_coc_regs (
		.core_clk            (core_clk),
		.reset               (reset),
		.scl_in              (scl),
		.sda_in              (sda),
		.sda_out             (sda_out),
		.sda_oe              (sda_oe),
		.strap_select_bits_n (straps_n),
		.clk_phase           (clk_phase),
		.clk_run             (clk_run),
		.mode                (mode)
	);

	coc_host_model i_coc_host_model (
		.core_clk (core_clk),
		.sda_oe   (sda_oe),
		.scl      (scl),
		.sda      (sda)
	);

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// gated clocks run four cycles high, four low, so the synchronised phase really moves
	always @(posedge core_clk) begin
		ph_cnt    <= ph_cnt + 3'h1;
		clk_phase <= {16{ph_cnt[2]}} | hold_hi;
	end

	function automatic logic [18:0] expect_out(input logic [7:0] r1, r2, r3, r4, r5);
		coc_pkg::coc_clk_en_t e;
		e.proc_clock              = r1[1];
		e.chipset_clock           = r1[0];
		e.single_memory_clock     = r1[3];
		e.pci_clock               = {r2[4:0], r2[6]};
		e.dedicated_48            = r3[5];
		e.shared_peripheral_clock = r3[4];
		e.memory_group            = r3[2:0];
		e.reference_out_first     = r5[0];
		e.reference_out_second    = r5[1];
		return {r3[6], r4[1], r4[0], e};
	endfunction : expect_out

	task automatic chk(input logic [18:0] got, input logic [18:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic chkb(input logic [7:0] got, input logic [7:0] exp);
		chk({11'h000, got}, {11'h000, exp});
	endtask : chkb

	task automatic do_reset(input logic [3:0] s);
		straps_n <= s;
		reset    <= 1'b1;
		repeat (10) @(posedge core_clk);
		reset <= 1'b0;
		repeat (10) @(posedge core_clk);
	endtask : do_reset

	task automatic t_reset_state(input logic [3:0] s);
		do_reset(s);
		chk({mode, clk_run}, 19'h0ffff);
		chkb({7'h00, sda_out}, 8'h00);
		i_coc_host_model.read_frame(8, rb, ack);
		chkb({7'h00, ack}, 8'h01);
		chkb(rb[1], 8'h0b);
		chkb(rb[2], 8'hff);
		chkb(rb[3], 8'h37);
		chkb(rb[4], {s, 4'h0});
		chkb(rb[5], 8'h03);
		chkb(rb[6], 8'h5a);
		$display("test reset_state done");
	endtask : t_reset_state

	// command and count contents are junk on purpose; count disagrees with the data
	task automatic t_pattern(input int p);
		q = {8'hd2, 8'ha5, 8'h01, 8'hff, pat[p][0], pat[p][1], pat[p][2], pat[p][3], pat[p][4], 8'h00};
		i_coc_host_model.write_frame(q, acks);
		chkb(8'(acks), 8'h0a);
		repeat (20) @(posedge core_clk);
		chk({mode, clk_run}, expect_out(pat[p][0], pat[p][1], pat[p][2], pat[p][3], pat[p][4]));
		i_coc_host_model.read_frame(7, rb, ack);
		chkb(rb[1], pat[p][0] & 8'h0b);
		chkb(rb[2], (pat[p][1] & 8'h5f) | 8'ha0);
		chkb(rb[3], pat[p][2] & 8'h77);
		chkb(rb[4], {straps_n, 2'b00, pat[p][3][1:0]});
		chkb(rb[5], pat[p][4] & 8'h03);
		chkb(rb[6], 8'h5a);
		$display("test pattern %0d done", p);
	endtask : t_pattern

	task automatic t_wrong_addr();
		q = {8'hd4, 8'h00, 8'h00, 8'h00, 8'h00};
		i_coc_host_model.write_frame(q, acks);
		chkb(8'(acks), 8'h00);
		chk({mode, clk_run}, 19'h7ffff);
		$display("test wrong_addr done");
	endtask : t_wrong_addr

	// slow host; processor pair phase stuck high must hold its run bit
	task automatic t_park();
		i_coc_host_model.half = 40;
		hold_hi <= 16'h0001;
		q = {8'hd2, 8'h00, 8'h00, 8'h00, 8'h00};
		i_coc_host_model.write_frame(q, acks);
		repeat (30) @(posedge core_clk);
		chk({3'h0, clk_run}, 19'h0fff9);
		hold_hi <= 16'h0000;
		repeat (20) @(posedge core_clk);
		chk({3'h0, clk_run}, 19'h0fff8);
		i_coc_host_model.half = 12;
		$display("test park done");
	endtask : t_park

	task automatic complete_run();
		$display("compares=%0d n_errors=%0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : complete_run

	initial begin
		reset     = 1'b1;
		straps_n  = 4'ha;
		ph_cnt    = 3'h0;
		clk_phase = 16'h0000;
		hold_hi   = 16'h0000;
		n_errors  = 0;
		compares  = 0;
		pat = '{'{8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, '{8'h08, 8'h40, 8'h51, 8'h02, 8'h02},
			'{8'hf7, 8'hbf, 8'ha6, 8'hfd, 8'hfd}, '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff}};
		t_reset_state(4'ha);
		for (int p = 0; p < 4; p++) begin
			t_pattern(p);
		end
		t_wrong_addr();
		t_park();
		t_reset_state(4'h5);
		complete_run();
	end

	// whole run is near 25k cycles
	initial begin
		repeat (60000) @(posedge core_clk);
		n_errors++;
		complete_run();
	end
endmodule : testbench
